//--- pbscd_burst_ctr.sv
// Two-bit wrapping burst address counter
`default_nettype none
`include "pbscd_map.svh"
module pbscd_burst_ctr (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Control
   input wire logic i_load,
   input wire logic [`PBSCD_BURST_W-1:0] i_base,
   input wire logic i_step,
   input wire logic i_linear,
   // Burst address low bits
   output logic [`PBSCD_BURST_W-1:0] o_lsb
);
   import pbscd_pkg::*;

   pbscd_ctr_t ctr_r;
   pbscd_ctr_t ctr_nxt;
   logic [`PBSCD_BURST_W-1:0] cnt_inc;

   // Next count and address, interleaved by xor, linear by add
   always_comb begin
      ctr_nxt = ctr_r;
      cnt_inc = ctr_r.cnt + 2'h1;
      if (i_load) begin
         ctr_nxt.base = i_base;
         ctr_nxt.cnt = 2'h0;
         ctr_nxt.lsb = i_base;
      end else if (i_step) begin
         ctr_nxt.cnt = cnt_inc;
         ctr_nxt.lsb = i_linear ? ctr_r.base + cnt_inc : ctr_r.base ^ cnt_inc;
      end
   end

   // State register
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ctr_r <= '0;
      end else begin
         ctr_r <= ctr_nxt;
      end
   end

   assign o_lsb = ctr_r.lsb;

endmodule : pbscd_burst_ctr
`default_nettype wire

//--- pbscd_ctl_model.sv
// Controller-side model that drives the burst memory bus pins
`default_nettype none
`include "pbscd_map.svh"
module pbscd_ctl_model (
   // Selects, strobes, advance and write controls, packed
   output logic [11:0] o_ctl,
   // Address and data toward the memory
   output logic [`PBSCD_ADDR_W-1:0] o_addr,
   output logic [`PBSCD_DATA_W-1:0] o_dq,
   // Asynchronous pins
   output logic o_output_enable_n,
   output logic o_sleep_request
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle pins at time zero, device not selected
   initial begin
      o_ctl = 12'hBFF;
      o_addr = 17'h00000;
      o_dq = 32'h0000_0000;
      o_output_enable_n = 1'b1;
      o_sleep_request = 1'b0;
   end

   // Present one cycle; data lines toggle when not writing
   task automatic put(input logic [11:0] c, input logic [16:0] a, input logic [31:0] d,
      input logic oe);
      logic wr;
      wr = !c[5] || (!c[4] && c[3:0] != 4'hF);
      o_ctl = c;
      o_addr = a;
      o_dq = wr ? d : ~o_dq;
      // Any write cycle, burst start or continue, gets the enable raised first
      o_output_enable_n = oe | wr;
   endtask : put

   // Sleep pin, raised only after a deselect by the caller
   task automatic nap(input logic on);
      o_sleep_request = on;
   endtask : nap
endmodule : pbscd_ctl_model
`default_nettype wire

//--- pbscd_map.svh
// Constants for the pipelined burst memory cycle decoder
`ifndef PBSCD_MAP_SVH
`define PBSCD_MAP_SVH

// ****************************************
// Widths
// ****************************************
`define PBSCD_ADDR_W 17
`define PBSCD_DATA_W 32
`define PBSCD_LANES 4
`define PBSCD_LANE_W 8
`define PBSCD_BURST_W 2

// ****************************************
// Reset values
// ****************************************
`define PBSCD_RST_DATA 32'h0000_0000
`define PBSCD_RST_LANES 4'h0
`define PBSCD_RST_BURST 2'h0

// ****************************************
// Timing
// ****************************************
`define PBSCD_CLK_PS 4000
`define PBSCD_TZZ_NS 8
`define PBSCD_ZZ_CYC ((`PBSCD_TZZ_NS * 1000 + `PBSCD_CLK_PS - 1) / `PBSCD_CLK_PS)

`endif

//--- pbscd_pkg.sv
// Types shared by the burst memory cycle decoder
`default_nettype none
`include "pbscd_map.svh"
package pbscd_pkg;

   // Cycle chosen at each clock edge
   typedef enum logic [2:0] {
      PBSCD_CYC_IDLE, PBSCD_CYC_DESEL, PBSCD_CYC_RD_EXT, PBSCD_CYC_WR_EXT,
      PBSCD_CYC_RD_NEXT, PBSCD_CYC_WR_NEXT, PBSCD_CYC_RD_CUR, PBSCD_CYC_WR_CUR
   } pbscd_cyc_t;

   // Sleep sequencing
   typedef enum logic [1:0] {
      PBSCD_ZZ_RUN, PBSCD_ZZ_ENTER, PBSCD_ZZ_SLEEP, PBSCD_ZZ_EXIT
   } pbscd_zz_t;

   // Burst counter state
   typedef struct packed {
      logic [`PBSCD_BURST_W-1:0] base;
      logic [`PBSCD_BURST_W-1:0] cnt;
      logic [`PBSCD_BURST_W-1:0] lsb;
   } pbscd_ctr_t;

   // Decoder state
   typedef struct packed {
      logic sleep_s1;
      logic sleep_s2;
      logic mode_s1;
      logic mode_s2;
      pbscd_zz_t zz;
      logic [1:0] zz_cnt;
      logic burst_active;
      logic [`PBSCD_ADDR_W-1:2] addr_hi;
      logic rd_issue;
      logic [`PBSCD_LANES-1:0] wr_lane;
      logic [`PBSCD_DATA_W-1:0] wdata;
      logic out_valid;
      logic [`PBSCD_DATA_W-1:0] out_data;
   } pbscd_state_t;

endpackage : pbscd_pkg
`default_nettype wire

//--- pbscd_top.sv
// Cycle decode, burst control and data bus gating of the burst memory
`default_nettype none
`include "pbscd_map.svh"
module pbscd_top (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Selects and strobes
   input wire logic i_primary_select_n,
   input wire logic i_expand_select_high,
   input wire logic i_expand_select_low_n,
   input wire logic i_processor_addr_strobe_n,
   input wire logic i_controller_addr_strobe_n,
   input wire logic i_burst_advance_n,
   // Write controls
   input wire logic i_global_write_n,
   input wire logic i_byte_write_gate_n,
   input wire logic [`PBSCD_LANES-1:0] i_byte_lane_write_n,
   // Address and asynchronous pins
   input wire logic [`PBSCD_ADDR_W-1:0] i_addr,
   input wire logic i_output_enable_n,
   input wire logic i_sleep_request,
   input wire logic i_burst_order,
   // Data bus, three signals
   input wire logic [`PBSCD_DATA_W-1:0] i_dq,
   output logic [`PBSCD_DATA_W-1:0] o_dq,
   output logic o_dq_oe_n,
   // Memory core side
   output logic [`PBSCD_ADDR_W-1:0] o_core_addr,
   output logic o_core_rd,
   output logic [`PBSCD_LANES-1:0] o_core_wr_lane,
   output logic [`PBSCD_DATA_W-1:0] o_core_wdata,
   input wire logic [`PBSCD_DATA_W-1:0] i_core_rdata,
   // Status
   output logic o_sleeping
);
   import pbscd_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   pbscd_state_t st_r;
   pbscd_state_t st_nxt;
   pbscd_cyc_t cyc;
   logic write_ind_n;
   logic [`PBSCD_LANES-1:0] lane_we;
   logic sel_all;
   logic processor_addr_strobe_n_ok;
   logic run;
   logic ctr_load;
   logic ctr_step;
   logic [`PBSCD_BURST_W-1:0] burst_lsb;

   // ****************************************
   // Write decode
   // ****************************************

   // Internal write indication and lane enables
   always_comb begin
      write_ind_n = ~(~i_global_write_n | (~i_byte_write_gate_n & ~(&i_byte_lane_write_n)));
      if (!i_global_write_n) begin
         lane_we = 4'hF;
      end else if (!i_byte_write_gate_n) begin
         lane_we = ~i_byte_lane_write_n;
      end else begin
         lane_we = 4'h0;
      end
   end

   // ****************************************
   // Cycle decode
   // ****************************************

   // Select and strobe qualification
   assign sel_all = ~i_primary_select_n & i_expand_select_high & ~i_expand_select_low_n;
   assign processor_addr_strobe_n_ok = ~i_processor_addr_strobe_n & ~i_primary_select_n;
   assign run = (st_r.zz == PBSCD_ZZ_RUN) & ~st_r.sleep_s2;

   // Choose the cycle for this edge
   always_comb begin
      cyc = PBSCD_CYC_IDLE;
      if (!run) begin
         cyc = PBSCD_CYC_IDLE;
      end else if (processor_addr_strobe_n_ok) begin
         cyc = sel_all ? PBSCD_CYC_RD_EXT : PBSCD_CYC_DESEL;
      end else if (!i_controller_addr_strobe_n) begin
         if (!sel_all) begin
            cyc = PBSCD_CYC_DESEL;
         end else if (!write_ind_n) begin
            cyc = PBSCD_CYC_WR_EXT;
         end else begin
            cyc = PBSCD_CYC_RD_EXT;
         end
      end else if (st_r.burst_active) begin
         if (!i_burst_advance_n) begin
            cyc = write_ind_n ? PBSCD_CYC_RD_NEXT : PBSCD_CYC_WR_NEXT;
         end else begin
            cyc = write_ind_n ? PBSCD_CYC_RD_CUR : PBSCD_CYC_WR_CUR;
         end
      end
   end

   // Burst counter control
   assign ctr_load = (cyc == PBSCD_CYC_RD_EXT) | (cyc == PBSCD_CYC_WR_EXT);
   assign ctr_step = (cyc == PBSCD_CYC_RD_NEXT) | (cyc == PBSCD_CYC_WR_NEXT);

   pbscd_burst_ctr u_burst_ctr (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_load(ctr_load),
      .i_base(i_addr[`PBSCD_BURST_W-1:0]),
      .i_step(ctr_step),
      .i_linear(~st_r.mode_s2),
      .o_lsb(burst_lsb)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      // Synchronisers for the asynchronous sleep and order pins
      st_nxt.sleep_s1 = i_sleep_request;
      st_nxt.sleep_s2 = st_r.sleep_s1;
      st_nxt.mode_s1 = i_burst_order;
      st_nxt.mode_s2 = st_r.mode_s1;
      // Sleep sequencing, one cycle in ENTER, two cycles in EXIT
      unique case (st_r.zz)
         PBSCD_ZZ_RUN: begin
            if (st_r.sleep_s2) begin
               st_nxt.zz = PBSCD_ZZ_ENTER;
               st_nxt.zz_cnt = 2'(`PBSCD_ZZ_CYC - 1);
            end
         end
         PBSCD_ZZ_ENTER: begin
            if (st_r.zz_cnt == 2'h1) begin
               st_nxt.zz = PBSCD_ZZ_SLEEP;
            end
            st_nxt.zz_cnt = st_r.zz_cnt - 2'h1;
         end
         PBSCD_ZZ_SLEEP: begin
            if (!st_r.sleep_s2) begin
               st_nxt.zz = PBSCD_ZZ_EXIT;
               st_nxt.zz_cnt = 2'(`PBSCD_ZZ_CYC);
            end
         end
         PBSCD_ZZ_EXIT: begin
            if (st_r.sleep_s2) begin
               st_nxt.zz = PBSCD_ZZ_SLEEP;
            end else if (st_r.zz_cnt == 2'h1) begin
               st_nxt.zz = PBSCD_ZZ_RUN;
            end
            st_nxt.zz_cnt = st_r.zz_cnt - 2'h1;
         end
      endcase
      // Access issue towards the core
      st_nxt.rd_issue = 1'b0;
      st_nxt.wr_lane = 4'h0;
      unique case (cyc)
         PBSCD_CYC_IDLE: begin
            if (!run) begin
               st_nxt.burst_active = 1'b0;
            end
         end
         PBSCD_CYC_DESEL: begin
            st_nxt.burst_active = 1'b0;
         end
         PBSCD_CYC_RD_EXT: begin
            st_nxt.burst_active = 1'b1;
            st_nxt.addr_hi = i_addr[`PBSCD_ADDR_W-1:2];
            st_nxt.rd_issue = 1'b1;
         end
         PBSCD_CYC_WR_EXT: begin
            st_nxt.burst_active = 1'b1;
            st_nxt.addr_hi = i_addr[`PBSCD_ADDR_W-1:2];
            st_nxt.wr_lane = lane_we;
            st_nxt.wdata = i_dq;
         end
         PBSCD_CYC_RD_NEXT, PBSCD_CYC_RD_CUR: begin
            st_nxt.rd_issue = 1'b1;
         end
         PBSCD_CYC_WR_NEXT, PBSCD_CYC_WR_CUR: begin
            st_nxt.wr_lane = lane_we;
            st_nxt.wdata = i_dq;
         end
      endcase
      // Output register follows the read one edge later
      st_nxt.out_valid = st_r.rd_issue & run;
      if (st_r.rd_issue) begin
         st_nxt.out_data = i_core_rdata;
      end
   end

   // State register
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   // Bus gating, enable pin combined without sampling
   assign o_dq_oe_n = ~(st_r.out_valid & ~(|st_r.wr_lane) & run & ~i_output_enable_n);
   assign o_dq = st_r.out_data;
   assign o_core_addr = {st_r.addr_hi, burst_lsb};
   assign o_core_rd = st_r.rd_issue;
   assign o_core_wr_lane = st_r.wr_lane;
   assign o_core_wdata = st_r.wdata;
   assign o_sleeping = (st_r.zz != PBSCD_ZZ_RUN);

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // Sleep request seen and held through entry
   sequence zz_raise;
      $rose(st_r.sleep_s2) && st_r.zz == PBSCD_ZZ_RUN;
   endsequence
   sequence zz_held;
      st_r.sleep_s2 [*3];
   endsequence

   chk_desel_tristate: assert property (cyc == PBSCD_CYC_DESEL |-> ##2 o_dq_oe_n)
      else $error("bus driven two edges after deselect");
   chk_desel_hold: assert property ((cyc == PBSCD_CYC_DESEL && o_core_rd && !i_output_enable_n)
      |=> st_r.out_valid && (i_output_enable_n || !o_dq_oe_n))
      else $error("bus released too early after deselect");
   chk_processor_addr_strobe_n_read: assert property ((run && processor_addr_strobe_n_ok && sel_all)
      |=> o_core_rd && o_core_wr_lane == 4'h0)
      else $error("processor strobe did not start a read");
   chk_controller_addr_strobe_n_write: assert property (cyc == PBSCD_CYC_WR_EXT
      |=> o_core_wr_lane == $past(lane_we) && o_core_wdata == $past(i_dq)
          && o_core_addr == $past(i_addr))
      else $error("controller strobe write not issued");
   chk_controller_addr_strobe_n_read: assert property ((run && !processor_addr_strobe_n_ok && !i_controller_addr_strobe_n && sel_all
      && write_ind_n) |=> o_core_rd && o_core_addr == $past(i_addr))
      else $error("controller strobe read not issued");
   chk_cont_step: assert property (ctr_step |=> o_core_addr[1:0] != $past(o_core_addr[1:0])
      && o_core_addr[16:2] == $past(o_core_addr[16:2]))
      else $error("burst address did not advance");
   chk_suspend_hold: assert property ((cyc == PBSCD_CYC_RD_CUR || cyc == PBSCD_CYC_WR_CUR)
      |=> $stable(o_core_addr))
      else $error("burst address moved on suspend");
   chk_lane_map: assert property ((run && !processor_addr_strobe_n_ok && !i_global_write_n
      && i_controller_addr_strobe_n
      && st_r.burst_active) |=> o_core_wr_lane == 4'hF)
      else $error("global write did not enable all lanes");
   chk_write_mask: assert property (|o_core_wr_lane |-> o_dq_oe_n)
      else $error("bus driven during a write");
   chk_read_drive: assert property ((o_core_rd && run) ##1 (run && !i_output_enable_n
      && o_core_wr_lane == 4'h0) |-> !o_dq_oe_n && o_dq == $past(i_core_rdata))
      else $error("read data not driven after output register");
   chk_sleep_entry: assert property (zz_raise ##0 zz_held |-> o_sleeping && o_dq_oe_n
      && !o_core_rd)
      else $error("sleep entry not completed");

endmodule : pbscd_top
`default_nettype wire

//--- pbscd_top_tb_top.sv
// Self-checking bench for the burst memory cycle decoder
`default_nettype none
`include "pbscd_map.svh"
module pbscd_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic rd;
      logic dsl;
      logic [3:0] lanes;
      logic [16:0] addr;
      logic [31:0] wd;
      logic oe;
   } pbscd_exp_t;

   logic i_clk_sys, i_rst, burst_order, oe_n, sleep_req, dq_oe_n, core_rd, sleeping, act;
   logic [11:0] ctl;
   logic [16:0] addr, core_addr;
   logic [31:0] ctl_dq, dut_dq, core_wdata, core_rdata, bus;
   logic [3:0] core_wr_lane;
   logic [14:0] ahi;
   logic [1:0] base, cnt;
   pbscd_exp_t p [3];
   int err_total, num_checks, cycles;

   // Core contents as a fixed function of address
   function automatic logic [31:0] rdata(input logic [16:0] a);
      return {a[14:0], a} ^ 32'h5A3C_96E1;
   endfunction : rdata

   // Shared data wire seen by the device
   assign bus = dq_oe_n ? ctl_dq : dut_dq;
   assign core_rdata = rdata(core_addr);

   pbscd_ctl_model ctl_u (.o_ctl(ctl), .o_addr(addr), .o_dq(ctl_dq),
      .o_output_enable_n(oe_n), .o_sleep_request(sleep_req));

   pbscd_top dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_primary_select_n(ctl[11]), .i_expand_select_high(ctl[10]),
      .i_expand_select_low_n(ctl[9]), .i_processor_addr_strobe_n(ctl[8]),
      .i_controller_addr_strobe_n(ctl[7]), .i_burst_advance_n(ctl[6]),
      .i_global_write_n(ctl[5]), .i_byte_write_gate_n(ctl[4]),
      .i_byte_lane_write_n(ctl[3:0]), .i_addr(addr), .i_output_enable_n(oe_n),
      .i_sleep_request(sleep_req), .i_burst_order(burst_order), .i_dq(bus),
      .o_dq(dut_dq), .o_dq_oe_n(dq_oe_n), .o_core_addr(core_addr), .o_core_rd(core_rd),
      .o_core_wr_lane(core_wr_lane), .o_core_wdata(core_wdata),
      .i_core_rdata(core_rdata), .o_sleeping(sleeping));

   // Clock, 4 ns period
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   // Verdict and end of run
   task automatic end_sim();
      if (err_total == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   // Hang guard
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Expected cycle from pins and the bench's own burst state
   function automatic pbscd_exp_t decode(input logic [11:0] c, input logic [16:0] a,
      input logic [31:0] d, input logic oe);
      pbscd_exp_t e;
      logic sel, wr, go;
      e = '0;
      e.oe = oe;
      sel = !c[11] && c[10] && !c[9];
      wr = !c[5] || (!c[4] && c[3:0] != 4'hF);
      go = 1'b0;
      if ((!c[8] && !c[11]) || !c[7]) begin
         e.dsl = !sel;
         act = sel;
         go = sel;
         ahi = a[16:2];
         base = a[1:0];
         cnt = 2'h0;
         if (!c[8] && !c[11]) wr = 1'b0;
      end else if (act) begin
         go = 1'b1;
         if (!c[6]) cnt = cnt + 2'h1;
      end
      e.addr = {ahi, burst_order ? base ^ cnt : base + cnt};
      e.rd = go && !wr;
      e.lanes = (!go || !wr) ? 4'h0 : (!c[5] ? 4'hF : ~c[3:0]);
      e.wd = d;
      return e;
   endfunction : decode

   // One bus cycle: check what is due, then present the next
   task automatic cyc(input logic [11:0] c, input logic [16:0] a, input logic [31:0] d,
      input logic oe);
      @(negedge i_clk_sys);
      // Core side shows the cycle taken at the last edge, bus the one before
      chk(core_rd, p[0].rd);
      chk(core_wr_lane, p[0].lanes);
      if (p[0].rd || p[0].lanes != 4'h0) chk(core_addr, p[0].addr);
      if (p[0].lanes != 4'h0) chk(core_wdata, p[0].wd);
      if (p[1].rd) begin
         chk(dut_dq, rdata(p[1].addr));
         chk(dq_oe_n, !(!p[0].oe && p[0].lanes == 4'h0));
      end
      if (p[1].dsl) chk(dq_oe_n, 1'b1);
      p[2] = p[1];
      p[1] = p[0];
      ctl_u.put(c, a, d, oe);
      p[0] = decode(c, a, ctl_dq, oe_n);
   endtask : cyc

   // Random cycle of a chosen kind
   task automatic rnd_op();
      logic [11:0] c;
      int k;
      k = $urandom_range(4);
      c = 12'($urandom);
      if ($urandom_range(7) != 0) c[11:9] = 3'b010;
      case (k)
         0: c[8:7] = 2'b01;
         1: c[8:7] = 2'b10;
         2, 3: c[8:7] = 2'b11;
         default: begin
            c[11] = 1'b1;
            c[8] = 1'b0;
         end
      endcase
      cyc(c, 17'($urandom), $urandom, 1'($urandom));
   endtask : rnd_op

   // Main sequence
   initial begin
      void'($urandom(54138));
      i_rst = 1'b1;
      burst_order = 1'b0;
      act = 1'b0;
      p = '{default: '0};
      err_total = 0;
      num_checks = 0;
      cycles = 0;
      repeat (16) @(negedge i_clk_sys);
      i_rst = 1'b0;
      chk(dq_oe_n, 1'b1);
      chk(core_rd, 1'b0);
      for (int o = 0; o < 2; o++) begin
         cyc(12'hB7F, 17'h00000, 32'h0, 1'b1);
         burst_order = 1'(o);
         repeat (4) cyc(12'hBFF, 17'h00000, 32'h0, 1'b1);
         for (int m = 0; m < 16; m++) begin
            cyc({3'b010, 2'b10, 3'b101, 4'(m)}, 17'($urandom), $urandom, 1'b0);
         end
         cyc({3'b010, 2'b10, 3'b100, 4'hF}, 17'($urandom), $urandom, 1'b0);
         repeat (5) cyc(12'hF8F, 17'h00000, $urandom, 1'b0);
         cyc(12'hF8F | 12'h040, 17'h00000, $urandom, 1'b0);
         cyc(12'hFFF, 17'h00000, 32'h0, 1'b0);
         repeat (4) cyc(12'hFBF, 17'h00000, 32'h0, 1'b0);
         cyc(12'h4CF, 17'($urandom), $urandom, 1'b0);
         cyc(12'h57F, 17'($urandom), 32'h0, 1'b1);
         repeat (100) rnd_op();
      end
      cyc(12'hB7F, 17'h00000, 32'h0, 1'b1);
      repeat (3) cyc(12'hBFF, 17'h00000, 32'h0, 1'b1);
      ctl_u.nap(1'b1);
      repeat (8) @(negedge i_clk_sys);
      chk(sleeping, 1'b1);
      ctl_u.put(12'h57F, 17'h1ABCD, 32'h0, 1'b0);
      repeat (3) begin
         @(negedge i_clk_sys);
         chk(core_rd, 1'b0);
         chk(dq_oe_n, 1'b1);
      end
      ctl_u.put(12'hBFF, 17'h00000, 32'h0, 1'b1);
      ctl_u.nap(1'b0);
      repeat (8) @(negedge i_clk_sys);
      chk(sleeping, 1'b0);
      act = 1'b0;
      p = '{default: '0};
      cyc(12'h57F, 17'h0F0F3, 32'h0, 1'b0);
      repeat (3) cyc(12'hB7F, 17'h00000, 32'h0, 1'b1);
      end_sim();
   end
endmodule : pbscd_top_tb_top
`default_nettype wire
